//--- i2s_pkg.sv
// i2s_pkg: register map, field positions and reset values of the two-wire slave
// assumes a 32-bit Avalon-MM slave port with byte addresses, one word per register
package i2s_pkg;
  // byte offsets of the register words
  localparam logic [4:0] OFS_RCV  = 5'h00;  // receive_buffer
  localparam logic [4:0] OFS_TRN  = 5'h04;  // transmit_holding
  localparam logic [4:0] OFS_BRG  = 5'h08;  // baud_reload
  localparam logic [4:0] OFS_CON  = 5'h0C;  // control
  localparam logic [4:0] OFS_STAT = 5'h10;  // status
  localparam logic [4:0] OFS_ADD  = 5'h14;  // own_slave_address
  // control fields
  localparam int CON_ENABLE  = 15;  // module_enable
  localparam int CON_RELEASE = 12;  // clock_release
  localparam int CON_TENBIT  = 10;  // ten_bit_address_mode
  localparam int CON_STRETCH = 6;   // receive_stretch_enable
  // status fields, bits 5..0 read-only
  localparam int ST_TXF   = 0;  // transmit_full_flag
  localparam int ST_RXF   = 1;  // receive_full_flag
  localparam int ST_DIR   = 2;  // last address direction bit
  localparam int ST_START = 3;  // start seen since stop
  localparam int ST_STOP  = 4;  // stop seen last
  localparam int ST_DATA  = 5;  // last received byte was data
  localparam int ST_OV    = 6;  // receive_overflow_flag
  localparam int ST_EVT   = 7;  // slave_event_flag
  localparam int ST_TEN   = 8;  // ten_bit_match_flag
  localparam int ST_RO_W  = 6;  // width of the read-only low field
  // register widths and reset values
  localparam int RBUF_W = 8;
  localparam int BRG_W  = 9;
  localparam int ADD_W  = 10;
  localparam int REG_W  = 16;
  localparam logic [15:0] CON_RESET  = 16'h1000;
  localparam logic [15:0] STAT_RESET = 16'h0000;
  localparam logic [4:0]  TEN_PREFIX = 5'h1E;  // 11110
  localparam logic [3:0]  BITS_BYTE  = 4'h8;   // last data bit count
  localparam logic [3:0]  BITS_ACK   = 4'h9;   // count after ninth rise
  // slave sequencer states
  typedef enum logic [2:0] {
    I2S_IDLE  = 3'b000,
    I2S_ADDR  = 3'b001,
    I2S_ADDR2 = 3'b010,
    I2S_RX    = 3'b011,
    I2S_TX    = 3'b100
  } i2s_state_t;
endpackage : i2s_pkg

//--- i2s_sync.sv
// i2s_sync: brings the bus clock and data pins into ref_clk and finds bus events
// assumes both pins are asynchronous to ref_clk and much slower than it
`timescale 1ns/1ps
`default_nettype none
module i2s_sync (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_s,
  output logic      sda_s,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_det,
  output logic      stop_det
);
  logic [1:0] scl_meta;  // first stage feeds only the second
  logic [1:0] sda_meta;
  logic       scl_d;     // delayed copy for edge finding
  logic       sda_d;

  ////////////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers, idle bus reads high
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_meta <= 2'h3;
      sda_meta <= 2'h3;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_meta <= {scl_meta[0], scl_in};
      sda_meta <= {sda_meta[0], sda_in};
      scl_d    <= scl_meta[1];
      sda_d    <= sda_meta[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // events come from the settled stage only
  assign scl_s     = scl_meta[1];
  assign sda_s     = sda_meta[1];
  assign scl_rise  = scl_meta[1] & ~scl_d;
  assign scl_fall  = ~scl_meta[1] & scl_d;
  // data moving while clock is high marks start or stop
  assign start_det = scl_meta[1] & scl_d & sda_d & ~sda_meta[1];
  assign stop_det  = scl_meta[1] & scl_d & ~sda_d & sda_meta[1];
endmodule : i2s_sync
`default_nettype wire

//--- i2s_slave.sv
// i2s_slave: two-wire bus slave with 7/10-bit address match and clock stretching
// assumes an external master drives the bus clock; pins are open drain outside
//
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module i2s_slave
  import i2s_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             slave_event_pulse
);
  // register storage, widths as the programmer sees them
  logic [RBUF_W-1:0] rcv_reg;       // receive_buffer
  logic [RBUF_W-1:0] trn_reg;       // transmit_holding
  logic [BRG_W-1:0]  brg_reg;       // baud_reload, stored only
  logic [REG_W-1:0]  con_reg;       // control without release bit
  logic              release_reg;   // clock_release
  logic [REG_W-1:0]  stat_reg;      // status
  logic [ADD_W-1:0]  add_reg;       // own_slave_address
  // bus sequencer
  i2s_state_t        state_reg;
  logic [3:0]        cnt_reg;       // bit count in current byte
  logic [7:0]        rsr_reg;       // receive_shift_register
  logic [7:0]        tsr_reg;       // transmit shifter
  logic              tx_pend_reg;   // transmit byte not yet loaded
  logic              ack_drv_reg;   // ack pulled low in ninth slot
  logic              wait_reg;      // bus waitrequest
  logic [31:0]       rdata_reg;
  logic              drive_lvl_reg; // open-drain level, always low
  logic              pulse_reg;
  // synchronised pin view
  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;

  i2s_sync u_sync (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .scl_s     (scl_s),
    .sda_s     (sda_s),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire req      = avs_read | avs_write;
  wire take     = req & ~wait_reg;            // request completes this edge
  wire wr_take  = take & avs_write;
  wire rd_take  = take & avs_read;
  wire hit_rcv  = avs_address == OFS_RCV;
  wire hit_trn  = avs_address == OFS_TRN;
  wire hit_brg  = avs_address == OFS_BRG;
  wire hit_con  = avs_address == OFS_CON;
  wire hit_stat = avs_address == OFS_STAT;
  wire hit_add  = avs_address == OFS_ADD;
  // byte lane merge of the low two lanes; upper lanes hold no bits
  wire [15:0] lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [15:0] wdat      = avs_writedata[15:0];
  wire [15:0] con_full  = {con_reg[15:13], release_reg, con_reg[11:0]};
  wire [15:0] con_wr    = (con_full & ~lane_mask) | (wdat & lane_mask);
  wire [15:0] stat_wr   = (stat_reg & ~lane_mask) | (wdat & lane_mask);
  wire [15:0] add_wr    = ({6'h00, add_reg} & ~lane_mask) | (wdat & lane_mask);
  wire [15:0] brg_wr    = ({7'h00, brg_reg} & ~lane_mask) | (wdat & lane_mask);
  wire        trn_wr    = wr_take & hit_trn & avs_byteenable[0];
  wire        rcv_rd    = rd_take & hit_rcv;
  // read mux, unmapped words read as zero
  wire [15:0] rd_mux =
    hit_rcv  ? {8'h00, rcv_reg} :
    hit_trn  ? {8'h00, trn_reg} :
    hit_brg  ? {7'h00, brg_reg} :
    hit_con  ? con_full :
    hit_stat ? stat_reg :
    hit_add  ? {6'h00, add_reg} : 16'h0000;

  ////////////////////////////////////////////////////////////////////////////////
  // control decode
  wire enable   = con_reg[CON_ENABLE];
  wire ten_mode = con_reg[CON_TENBIT];
  wire stretch  = con_reg[CON_STRETCH];
  wire txf      = stat_reg[ST_TXF];
  wire rxf      = stat_reg[ST_RXF];
  wire ov       = stat_reg[ST_OV];
  wire ten_hit  = stat_reg[ST_TEN];
  wire rw_bit   = rsr_reg[0];
  // address comparisons on the completed shift byte
  wire m7   = rsr_reg[7:1] == add_reg[6:0];
  wire m10h = (rsr_reg[7:3] == TEN_PREFIX) & (rsr_reg[2:1] == add_reg[9:8]);
  wire m10l = rsr_reg == add_reg[7:0];
  // slot boundaries on the falling bus clock
  wire byte_end = scl_fall & (cnt_reg == BITS_BYTE);
  wire ack_end  = scl_fall & (cnt_reg == BITS_ACK);
  wire active   = state_reg != I2S_IDLE;
  // address byte outcome at the eighth falling edge
  wire addr_tx  = ten_mode ? (m10h & rw_bit & ten_hit) : (m7 & rw_bit);
  wire addr_ack = ten_mode ? (m10h & (~rw_bit | ten_hit)) : m7;
  // receive byte outcome
  wire rx_load  = ~rxf;
  wire rx_ack   = ~rxf & ~ov;
  // master answered with low data in ninth slot of a transmit byte
  logic mst_ack_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, then the answer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wait_reg  <= ~(req & wait_reg);
      rdata_reg <= {16'h0000, rd_mux};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // software-only registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      con_reg <= CON_RESET;
      brg_reg <= '0;
      add_reg <= '0;
      trn_reg <= '0;
    end else begin
      if (wr_take & hit_con) begin
        con_reg <= con_wr;
      end
      if (wr_take & hit_brg) begin
        brg_reg <= brg_wr[BRG_W-1:0];
      end
      if (wr_take & hit_add) begin
        add_reg <= add_wr[ADD_W-1:0];
      end
      if (trn_wr) begin
        trn_reg <= wdat[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // clock release: hardware clears at ninth fall, a software set wins
  wire rel_set   = wr_take & hit_con & con_wr[CON_RELEASE];
  wire rel_sw_cl = wr_take & hit_con & ~con_wr[CON_RELEASE] & stretch;
  wire tx_stall  = (state_reg == I2S_TX) & ack_end & mst_ack_reg & ~txf;
  wire ad_stall  = (state_reg == I2S_ADDR) & ack_end & addr_tx & ~txf;
  wire rx_stall  = (state_reg == I2S_RX) & ack_end & stretch & rxf;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      release_reg <= 1'b1;
    end else if (rel_set) begin
      release_reg <= 1'b1;
    end else if (tx_stall | ad_stall | rx_stall | rel_sw_cl) begin
      release_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // status flags: hardware sets are applied after software writes
  wire rx_done  = (state_reg == I2S_RX) & byte_end;
  wire ev_pulse = ack_end & (state_reg != I2S_IDLE) & (ack_drv_reg | state_reg == I2S_TX
                  | state_reg == I2S_RX);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stat_reg <= STAT_RESET;
    end else begin
      if (wr_take & hit_stat) begin
        stat_reg[REG_W-1:ST_RO_W] <= stat_wr[REG_W-1:ST_RO_W];
      end
      if (rcv_rd) begin
        stat_reg[ST_RXF] <= 1'b0;
      end
      if (state_reg == I2S_TX & tx_pend_reg & release_reg & ~ack_drv_reg) begin
        stat_reg[ST_TXF] <= 1'b0;
      end
      if (trn_wr) begin
        stat_reg[ST_TXF] <= 1'b1;                                    // a new byte is not lost
      end
      if (rx_done & rx_load) begin
        stat_reg[ST_RXF] <= 1'b1;
      end
      if (rx_done & rxf) begin
        stat_reg[ST_OV] <= 1'b1;
      end
      if (rx_done) begin
        stat_reg[ST_DATA] <= 1'b1;
      end
      if (ev_pulse) begin
        stat_reg[ST_EVT] <= 1'b1;
      end
      if (start_det) begin
        stat_reg[ST_START] <= 1'b1;
        stat_reg[ST_STOP]  <= 1'b0;
      end
      if (stop_det) begin
        stat_reg[ST_START] <= 1'b0;
        stat_reg[ST_STOP]  <= 1'b1;
        stat_reg[ST_TEN]   <= 1'b0;
      end
      if (byte_end & state_reg == I2S_ADDR) begin
        stat_reg[ST_DATA] <= 1'b0;
        stat_reg[ST_DIR]  <= rw_bit;
        if (ten_mode & ~(addr_tx)) begin
          stat_reg[ST_TEN] <= 1'b0;
        end
      end
      if (byte_end & state_reg == I2S_ADDR2) begin
        stat_reg[ST_TEN] <= m10l;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // receive buffer: written only from a finished data byte, never by an address
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rcv_reg <= '0;
    end else if (rx_done & rx_load) begin
      rcv_reg <= rsr_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bit counter and shift register, sampled on the rising bus clock
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg     <= '0;
      rsr_reg     <= '0;
      mst_ack_reg <= 1'b0;
    end else if (start_det) begin
      cnt_reg <= '0;
    end else if (active & scl_rise) begin
      cnt_reg <= cnt_reg + 4'h1;
      if (cnt_reg < BITS_BYTE) begin
        rsr_reg <= {rsr_reg[6:0], sda_s};
      end else begin
        mst_ack_reg <= ~sda_s;
      end
    end else if (ack_end) begin
      cnt_reg <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer: start, address, second address byte, receive or transmit
  i2s_state_t state_next;
  always_comb begin
    state_next = state_reg;
    if (~enable | stop_det) begin
      state_next = I2S_IDLE;
    end else if (start_det) begin
      state_next = I2S_ADDR;
    end else if (byte_end & ~ack_drv_reg) begin
      unique case (state_reg)
        I2S_ADDR:  state_next = addr_ack ? state_reg : I2S_IDLE;
        I2S_ADDR2: state_next = m10l ? state_reg : I2S_IDLE;
        default:   state_next = state_reg;
      endcase
    end else if (ack_end) begin
      unique case (state_reg)
        I2S_ADDR:  state_next = addr_tx ? I2S_TX :
                                ten_mode ? I2S_ADDR2 : I2S_RX;
        I2S_ADDR2: state_next = I2S_RX;
        I2S_TX:    state_next = mst_ack_reg ? I2S_TX : I2S_IDLE;
        default:   state_next = state_reg;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= I2S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // acknowledge drive for address and receive bytes in the ninth slot
  wire ack_now = (state_reg == I2S_ADDR & addr_ack) | (state_reg == I2S_ADDR2 & m10l)
               | (state_reg == I2S_RX & rx_ack);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_drv_reg <= 1'b0;
    end else if (~enable | start_det | stop_det | ack_end) begin
      ack_drv_reg <= 1'b0;
    end else if (byte_end & state_reg != I2S_TX) begin
      ack_drv_reg <= ack_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // transmit shifter: loads once the clock is released, shifts on falling edges
  wire tx_enter = ack_end & ((state_reg == I2S_ADDR & addr_tx) |
                             (state_reg == I2S_TX & mst_ack_reg));
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tsr_reg     <= 8'hFF;
      tx_pend_reg <= 1'b0;
    end else if (~enable | start_det | stop_det) begin
      tsr_reg     <= 8'hFF;
      tx_pend_reg <= 1'b0;
    end else if (tx_enter) begin
      tsr_reg     <= 8'hFF;
      tx_pend_reg <= 1'b1;
    end else if (state_reg == I2S_TX & tx_pend_reg & release_reg) begin
      tsr_reg     <= trn_reg;
      tx_pend_reg <= 1'b0;
    end else if (state_reg == I2S_TX & scl_fall & cnt_reg != '0) begin
      tsr_reg <= {tsr_reg[6:0], 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin drivers; a stretch starts only while the clock already reads low
  wire tx_slot  = (cnt_reg < BITS_BYTE) | ((cnt_reg == BITS_BYTE) & scl_s); // last bit to 8th fall
  wire sda_low  = ack_drv_reg | (state_reg == I2S_TX & ~tx_pend_reg & tx_slot
                  & ~tsr_reg[7]);
  wire scl_hold = enable & ~release_reg & (scl_oe | ~scl_s);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_oe        <= 1'b0;
      sda_oe        <= 1'b0;
      drive_lvl_reg <= 1'b0;
      pulse_reg     <= 1'b0;
    end else begin
      scl_oe        <= scl_hold;
      sda_oe        <= enable & sda_low;
      drive_lvl_reg <= 1'b0;
      pulse_reg     <= ev_pulse;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops
  assign scl_out           = drive_lvl_reg;
  assign sda_out           = drive_lvl_reg;
  assign avs_waitrequest   = wait_reg;
  assign avs_readdata      = rdata_reg;
  assign slave_event_pulse = pulse_reg;
endmodule : i2s_slave
`default_nettype wire

//--- i2s_slave_sva.sv
// i2s_slave_sva: port-level checks of the two-wire slave
// assumes it is bound to i2s_slave and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module i2s_slave_sva
  import i2s_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        scl_in,
  input wire logic        scl_out,
  input wire logic        scl_oe,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        slave_event_pulse
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  // read accepted this edge; software setting the clock release bit
  wire logic rd_ok  = avs_read && !avs_waitrequest;
  wire logic rel_wr = avs_write && !avs_waitrequest && avs_address == OFS_CON
                      && avs_writedata[CON_RELEASE];
  ////////////////////////////////////////////////////////////////////////////
  wait_one_a: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("request not answered after one wait");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  rcv_width_a: assert property (rd_ok && avs_address == OFS_RCV |-> avs_readdata[15:8] == 8'h00)
    else $error("receive buffer wider than a byte");
  brg_width_a: assert property (rd_ok && avs_address == OFS_BRG |-> avs_readdata[15:9] == 7'h00)
    else $error("baud reload wider than nine bits");
  unmapped_zero_a: assert property (rd_ok && avs_address > OFS_ADD |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  pulse_one_a: assert property (slave_event_pulse |=> !slave_event_pulse)
    else $error("event pulse longer than one cycle");
  pulse_low_a: assert property (slave_event_pulse |-> !scl_in)
    else $error("event pulse outside bus clock low");
  data_change_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line changed while bus clock high");
  stretch_hold_a: assert property (scl_oe && !rel_wr && !$past(rel_wr) && !$past(rel_wr, 2)
    |=> scl_oe) else $error("stretch ended without release");
  drive_low_a: assert property (!(scl_oe && scl_out) && !(sda_oe && sda_out))
    else $error("driven pin not pulled low");
  // main scenarios reached
  cover property ($rose(scl_oe));
  cover property (slave_event_pulse);
  cover property (rel_wr);
endmodule : i2s_slave_sva
`default_nettype wire

//--- i2s_bus_master.sv
// i2s_bus_master: behavioural master on the two-wire bus, 125 ns bit time
// assumes pull-ups on both lines; it only pulls them low
`timescale 1ns/1ps
`default_nettype none
module i2s_bus_master (
  input  wire logic scl,     // wired bus clock level
  input  wire logic sda,     // wired data level
  output var logic  scl_low, // pull bus clock low
  output var logic  sda_low  // pull data low
);
  localparam realtime QTR = 31.25; // quarter bit time
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // release the clock; a stretching slave makes us wait here
  task automatic rise();
    scl_low = 1'b0;
    wait (scl === 1'b1);
    #QTR;
  endtask : rise
  // start, or repeated start when the clock is low
  task automatic start();
    sda_low = 1'b0;
    #QTR;
    rise();
    sda_low = 1'b1;
    #QTR;
    scl_low = 1'b1;
    #QTR;
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    #QTR;
    rise();
    sda_low = 1'b0;
    #QTR;
  endtask : stop
  // one bit: data set while clock low, sampled in the high half
  task automatic bit_x(input logic v, output logic s);
    sda_low = !v;
    #QTR;
    rise();
    s = sda;
    #QTR;
    scl_low = 1'b1;
    #QTR;
  endtask : bit_x
  // msb first byte, then the ninth bit ai driven and ak sampled
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] r,
                      output logic ak);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r[i]);
    end
    bit_x(ai, ak);
  endtask : xfer
endmodule : i2s_bus_master
`default_nettype wire

//--- i2s_slave_tb.sv
// i2s_slave_tb: register and bus-pin tests of the two-wire slave
// assumes pull-ups on both pins and the behavioural bus master
`timescale 1ns/1ps
`default_nettype none
module i2s_slave_tb;
  import i2s_pkg::*;
  typedef struct packed {logic [4:0] a; logic [15:0] d; logic [15:0] e;} i2s_row_t;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h3; // only lanes 0 and 1 carry data
  logic [31:0] avs_readdata, q;
  logic        avs_waitrequest, scl_out, scl_oe, sda_out, sda_oe, slave_event_pulse;
  logic        m_scl, m_sda, k;
  logic [7:0]  b;
  int          n_mismatch = 0, checks = 0, cyc = 0, n_pulse = 0;
  // wired levels: pull-up unless someone drives low
  wire logic scl = !m_scl && (!scl_oe || scl_out);
  wire logic sda = !m_sda && (!sda_oe || sda_out);
  // register table: address, written value, value read back
  i2s_row_t rows [8] = '{'{OFS_BRG, 16'hFFFF, 16'h01FF}, '{OFS_ADD, 16'hFFFF, 16'h03FF},
    '{OFS_CON, 16'hFFFF, 16'hFFFF}, '{OFS_CON, 16'h0040, 16'h0040},
    '{OFS_STAT, 16'hFFFF, 16'hFFC0}, '{OFS_STAT, 16'h0000, 16'h0000},
    '{OFS_RCV, 16'hFFFF, 16'h0000}, '{5'h18, 16'hFFFF, 16'h0000}};
  i2s_slave dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .slave_event_pulse(slave_event_pulse));
  i2s_bus_master m (.scl(scl), .sda(sda), .scl_low(m_scl), .sda_low(m_sda));
  ////////////////////////////////////////////////////////////////////////////
  always #5 ref_clk = !ref_clk;
  // count event pulses; cut a hang short well past the expected run
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (slave_event_pulse === 1'b1) n_pulse <= n_pulse + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // one bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_write <= w;
    avs_read <= !w;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    chk(q, {16'h0000, e});
  endtask : rd
  task automatic tx(input logic [7:0] d, input logic e);
    m.xfer(d, 1'b1, b, k);
    chk(k, e);
  endtask : tx
  task automatic rx(input logic ma, input logic [7:0] e);
    m.xfer(8'hFF, ma, b, k);
    chk(b, e);
  endtask : rx
  task automatic close_out();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(OFS_CON, CON_RESET);
    rd(OFS_STAT, STAT_RESET);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    // disabled slave ignores its own address
    bus(1'b1, OFS_ADD, 16'h005A);
    bus(1'b1, OFS_CON, 16'h1000);
    m.start();
    tx(8'hB4, 1'b1);
    m.stop();
    // seven-bit receive with stretching, full buffer and overflow
    bus(1'b1, OFS_CON, 16'h9040);
    m.start();
    tx(8'hB6, 1'b1);
    m.stop();
    m.start();
    tx(8'hB4, 1'b0);
    rd(OFS_STAT, 16'h0088);
    tx(8'h3C, 1'b0);
    rd(OFS_STAT, 16'h00AA);
    rd(OFS_CON, 16'h8040);
    chk(scl_oe, 1'b1);
    rd(OFS_RCV, 16'h003C);
    bus(1'b1, OFS_CON, 16'h9040);
    tx(8'h77, 1'b0);
    bus(1'b1, OFS_CON, 16'h9040);
    tx(8'h11, 1'b1);
    rd(OFS_RCV, 16'h0077);
    bus(1'b1, OFS_CON, 16'h9040);
    tx(8'h22, 1'b1);
    rd(OFS_RCV, 16'h0022);
    chk(n_pulse, 32'd5);
    bus(1'b1, OFS_CON, 16'h9040);
    m.stop();
    bus(1'b1, OFS_STAT, 16'h0000);
    // seven-bit transmit: stretch after address, early load skips it
    bus(1'b1, OFS_CON, 16'h9000);
    m.start();
    tx(8'hB5, 1'b0);
    rd(OFS_CON, 16'h8000);
    chk(scl_oe, 1'b1);
    bus(1'b1, OFS_TRN, 16'h0096);
    bus(1'b1, OFS_CON, 16'h9000);
    fork
      rx(1'b0, 8'h96);
      begin
        repeat (40) @(posedge ref_clk);
        bus(1'b1, OFS_TRN, 16'h00C3);
      end
    join
    rd(OFS_CON, 16'h9000);
    chk(scl_oe, 1'b0);
    rx(1'b1, 8'hC3);
    repeat (8) @(posedge ref_clk);
    chk(n_pulse, 32'd8);
    m.stop();
    // ten-bit: two address bytes, data, then restart for transmit
    bus(1'b1, OFS_ADD, 16'h02C3);
    bus(1'b1, OFS_CON, 16'h9400);
    m.start();
    tx(8'hF4, 1'b0);
    tx(8'hC3, 1'b0);
    bus(1'b0, OFS_STAT, 16'h0000);
    chk(q[ST_TEN], 1'b1);
    tx(8'h5E, 1'b0);
    rd(OFS_RCV, 16'h005E);
    m.start();
    tx(8'hF5, 1'b0);
    bus(1'b1, OFS_TRN, 16'h00A7);
    bus(1'b1, OFS_CON, 16'h9400);
    rx(1'b1, 8'hA7);
    m.stop();
    m.start();
    tx(8'hF2, 1'b1);
    m.stop();
    close_out();
  end
endmodule : i2s_slave_tb
bind i2s_slave i2s_slave_sva u_sva (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .slave_event_pulse(slave_event_pulse));
`default_nettype wire
